// File: wwd_top.sv
// windowed watchdog and reset supervisor top level
// Behaviour
// - missed open window: pulse of period/40
// - closed-window kick: reset, restart sequence
// - no kicks: repeating reset square wave
// - repeat until open-window falling kick or third missed period
// - power-on delay holds reset, ignores kicks
// - delay over: release reset, start closed
// - open-window kick restarts closed window
// - supply dip over 5 us forces reset
// - enable inactive whenever reset active
// - enable after three good kicks
// - three missed periods enter sleep mode
// - sleep mode: 3 ms pulse every second
// - any kick edge leaves sleep mode
// - closed then open window sizing
// - power-on delay equals one period
`timescale 1ns/1ps
`include "wwd_regs.svh"

module wwd_top #(
	// watchdog period in cycles
	parameter int unsigned PERIOD_CYC = `WWD_PERIOD_US * `WWD_CLK_MHZ,
	// sleep-detect repeat interval in cycles
	parameter int unsigned SLEEP_PERIOD_CYC = `WWD_SLEEP_PERIOD_US * `WWD_CLK_MHZ,
	// sleep-detect pulse width in cycles
	parameter int unsigned SLEEP_PULSE_CYC = `WWD_SLEEP_PULSE_US * `WWD_CLK_MHZ
)(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// host side pins
	input wire logic i_watchdog_kick,
	input wire logic i_supply_ok,
	// supervisor outputs
	output logic o_host_init_pulse_n,
	output logic o_sys_enable_n,
	output logic o_sleep_mode
);

	// ------------------------------------------------------------
	// window lengths
	// ------------------------------------------------------------

	localparam int unsigned CLOSED_CYC = PERIOD_CYC * (`WWD_PCT_FULL - `WWD_OPEN_PCT) / `WWD_PCT_FULL;
	localparam int unsigned OPEN_CYC = 2 * PERIOD_CYC * `WWD_OPEN_PCT / `WWD_PCT_FULL;
	localparam int unsigned PULSE_CYC = PERIOD_CYC / `WWD_PULSE_DIV;
	// last count of each phase
	localparam logic [`WWD_CNT_W-1:0] POR_LAST = `WWD_CNT_W'(PERIOD_CYC - 1);
	localparam logic [`WWD_CNT_W-1:0] CLOSED_LAST = `WWD_CNT_W'(CLOSED_CYC - 1);
	localparam logic [`WWD_CNT_W-1:0] OPEN_LAST = `WWD_CNT_W'(OPEN_CYC - 1);
	localparam logic [`WWD_CNT_W-1:0] PULSE_LAST = `WWD_CNT_W'(PULSE_CYC - 1);
	localparam logic [`WWD_CNT_W-1:0] SLP_IDLE_LAST = `WWD_CNT_W'(SLEEP_PERIOD_CYC - SLEEP_PULSE_CYC - 1);
	localparam logic [`WWD_CNT_W-1:0] SLP_PULSE_LAST = `WWD_CNT_W'(SLEEP_PULSE_CYC - 1);

	// ------------------------------------------------------------
	// pin conditioning
	// ------------------------------------------------------------

	// synchronised pins
	logic [1:0] syn;
	// kick level after synchroniser
	logic kick_s;
	// filtered supply good
	logic uv_ok;
	// kick edges
	logic kick_fall;
	logic kick_edge;
	// register state and next value, read by the edge detectors below
	wwd_pkg::wwd_top_st_t q;
	wwd_pkg::wwd_top_st_t d;

	wwd_sync u_sync (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_async({i_supply_ok, i_watchdog_kick}),
		.o_sync(syn)
	);

	wwd_uv_filter u_uv (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_level(syn[`WWD_SYN_SUPPLY]),
		.o_ok(uv_ok)
	);

	assign kick_s = syn[`WWD_SYN_KICK];
	assign kick_fall = q.kick_prev & ~kick_s;
	assign kick_edge = q.kick_prev ^ kick_s;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------

	// next-state logic; a supply dip overrides every phase
	always_comb
	begin
		d = q;
		d.kick_prev = kick_s;
		d.cnt = q.cnt + `WWD_CNT_ONE;
		if (!uv_ok)
		begin
			d.state = wwd_pkg::ST_DOWN;
			d.cnt = `WWD_CNT_ZERO;
			d.rst_n = 1'b0;
			d.en_n = 1'b1;
			d.good = '0;
			d.miss = '0;
			d.sleep = 1'b0;
		end
		else
		begin
			unique case (q.state)
				// supply just came good
				wwd_pkg::ST_DOWN:
				begin
					d.state = wwd_pkg::ST_POR;
					d.cnt = `WWD_CNT_ZERO;
				end
				// power-on delay, kicks ignored
				wwd_pkg::ST_POR:
				begin
					if (q.cnt == POR_LAST)
					begin
						d.state = wwd_pkg::ST_CLOSED;
						d.cnt = `WWD_CNT_ZERO;
						d.rst_n = 1'b1;
					end
				end
				// closed window
				wwd_pkg::ST_CLOSED:
				begin
					if (kick_fall)
					begin
						d.state = wwd_pkg::ST_PULSE;
						d.cnt = `WWD_CNT_ZERO;
						d.rst_n = 1'b0;
						d.en_n = 1'b1;
						d.good = '0;
						d.miss = '0;
					end
					else if (q.cnt == CLOSED_LAST)
					begin
						d.state = wwd_pkg::ST_OPEN;
						d.cnt = `WWD_CNT_ZERO;
					end
				end
				// open window
				wwd_pkg::ST_OPEN:
				begin
					if (kick_fall)
					begin
						d.state = wwd_pkg::ST_CLOSED;
						d.cnt = `WWD_CNT_ZERO;
						d.miss = '0;
						if (q.good != `WWD_GOOD_KICKS)
						begin
							d.good = q.good + 2'h1;
						end
						if (q.good >= `WWD_GOOD_KICKS - 2'h1)
						begin
							d.en_n = 1'b0;
						end
					end
					else if (q.cnt == OPEN_LAST)
					begin
						d.state = wwd_pkg::ST_PULSE;
						d.cnt = `WWD_CNT_ZERO;
						d.rst_n = 1'b0;
						d.en_n = 1'b1;
						d.good = '0;
						if (q.miss != `WWD_SLEEP_MISSES)
						begin
							d.miss = q.miss + 2'h1;
						end
					end
				end
				// watchdog reset pulse, kicks ignored
				wwd_pkg::ST_PULSE:
				begin
					if (q.cnt == PULSE_LAST)
					begin
						d.cnt = `WWD_CNT_ZERO;
						d.rst_n = 1'b1;
						if (q.miss == `WWD_SLEEP_MISSES)
						begin
							d.state = wwd_pkg::ST_SLEEP;
							d.sleep = 1'b1;
						end
						else
						begin
							d.state = wwd_pkg::ST_CLOSED;
						end
					end
				end
				// sleep mode: reset released in ST_SLEEP, held low in ST_SLEEP_PULSE
				wwd_pkg::ST_SLEEP,
				wwd_pkg::ST_SLEEP_PULSE:
				begin
					if (kick_edge)
					begin
						d.state = wwd_pkg::ST_CLOSED;
						d.cnt = `WWD_CNT_ZERO;
						d.rst_n = 1'b1;
						d.miss = '0;
						d.sleep = 1'b0;
					end
					else if (q.state == wwd_pkg::ST_SLEEP && q.cnt == SLP_IDLE_LAST)
					begin
						d.state = wwd_pkg::ST_SLEEP_PULSE;
						d.cnt = `WWD_CNT_ZERO;
						d.rst_n = 1'b0;
					end
					else if (q.state == wwd_pkg::ST_SLEEP_PULSE && q.cnt == SLP_PULSE_LAST)
					begin
						d.state = wwd_pkg::ST_SLEEP;
						d.cnt = `WWD_CNT_ZERO;
						d.rst_n = 1'b1;
					end
				end
				// illegal code: treat as power down
				default:
				begin
					d.state = wwd_pkg::ST_DOWN;
					d.cnt = `WWD_CNT_ZERO;
					d.rst_n = 1'b0;
					d.en_n = 1'b1;
					d.good = '0;
					d.miss = '0;
					d.sleep = 1'b0;
				end
			endcase
		end
	end

	// registers; reset holds the host in reset with enable off
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			q.state <= wwd_pkg::ST_DOWN;
			q.cnt <= `WWD_CNT_ZERO;
			q.good <= '0;
			q.miss <= '0;
			q.kick_prev <= 1'b1;
			q.rst_n <= 1'b0;
			q.en_n <= 1'b1;
			q.sleep <= 1'b0;
		end
		else
		begin
			q <= d;
		end
	end

	// outputs straight from flops
	assign o_host_init_pulse_n = q.rst_n;
	assign o_sys_enable_n = q.en_n;
	assign o_sleep_mode = q.sleep;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	enable_off_rst_a: assert property (!o_host_init_pulse_n |-> o_sys_enable_n)
		else $error("enable active while reset asserted");

	miss_pulse_a: assert property (
		q.state == wwd_pkg::ST_OPEN && q.cnt == OPEN_LAST && !kick_fall && uv_ok
		|=> q.state == wwd_pkg::ST_PULSE && !o_host_init_pulse_n)
		else $error("no reset pulse after missed window");

	early_kick_a: assert property (
		q.state == wwd_pkg::ST_CLOSED && kick_fall && uv_ok
		|=> !o_host_init_pulse_n && q.cnt == `WWD_CNT_ZERO)
		else $error("early kick did not reset");

	por_hold_a: assert property (q.state == wwd_pkg::ST_POR |-> !o_host_init_pulse_n)
		else $error("reset released during power-on delay");

	por_release_a: assert property (
		q.state == wwd_pkg::ST_POR && q.cnt == POR_LAST && uv_ok
		|=> q.state == wwd_pkg::ST_CLOSED && o_host_init_pulse_n)
		else $error("power-on delay did not release");

	good_kick_a: assert property (
		q.state == wwd_pkg::ST_OPEN && kick_fall && uv_ok
		|=> q.state == wwd_pkg::ST_CLOSED && q.cnt == `WWD_CNT_ZERO && o_host_init_pulse_n)
		else $error("open-window kick did not restart");

	dip_reset_a: assert property (!uv_ok |=> !o_host_init_pulse_n && o_sys_enable_n)
		else $error("supply dip did not force reset");

	enable_gate_a: assert property (
		$fell(o_sys_enable_n) |-> $past(q.state) == wwd_pkg::ST_OPEN && $past(q.good) == 2'h2)
		else $error("enable without three good kicks");

	sleep_entry_a: assert property (
		$rose(o_sleep_mode) |-> $past(q.miss) == `WWD_SLEEP_MISSES && o_host_init_pulse_n)
		else $error("sleep mode entered early");

	sleep_exit_a: assert property (
		o_sleep_mode && kick_edge && uv_ok |=> !o_sleep_mode && q.state == wwd_pkg::ST_CLOSED)
		else $error("kick edge did not leave sleep");

endmodule // wwd_top

// File: wwd_regs.svh
// timing and reset constants for the windowed watchdog supervisor
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH

// clock rate
`define WWD_CLK_MHZ 20
// watchdog period, microseconds (typical tuning)
`define WWD_PERIOD_US 100000
// open window is twice this percent of the period; closed window is the period less this percent
`define WWD_OPEN_PCT 20
`define WWD_PCT_FULL 100
// kick-fail pulse is the period divided by this
`define WWD_PULSE_DIV 40
// sleep-detect pulse and repeat interval, microseconds
`define WWD_SLEEP_PULSE_US 3000
`define WWD_SLEEP_PERIOD_US 1000000
// supply dip filter, nanoseconds, rounded up to cycles
`define WWD_UV_NS 5000
`define WWD_NS_PER_US 1000
`define WWD_UV_CYC ((`WWD_UV_NS * `WWD_CLK_MHZ + `WWD_NS_PER_US - 1) / `WWD_NS_PER_US)
`define WWD_UV_CNT_W 8
// good kicks before enable, missed windows before sleep
`define WWD_GOOD_KICKS 2'h3
`define WWD_SLEEP_MISSES 2'h3
// counter width and constants
`define WWD_CNT_W 32
`define WWD_CNT_ZERO 32'h0
`define WWD_CNT_ONE 32'h1
// synchroniser bit positions and reset value (kick idles high)
`define WWD_SYN_KICK 0
`define WWD_SYN_SUPPLY 1
`define WWD_SYN_RST 2'h1

`endif

// File: wwd_pkg.sv
// types shared by the windowed watchdog supervisor modules
`include "wwd_regs.svh"

package wwd_pkg;

	// supervisor sequence states
	typedef enum logic [2:0] {
		ST_DOWN,
		ST_POR,
		ST_CLOSED,
		ST_OPEN,
		ST_PULSE,
		ST_SLEEP,
		ST_SLEEP_PULSE
	} wwd_state_t;

	// top-level state
	typedef struct packed {
		wwd_state_t state;
		logic [`WWD_CNT_W-1:0] cnt;
		logic [1:0] good;
		logic [1:0] miss;
		logic kick_prev;
		logic rst_n;
		logic en_n;
		logic sleep;
	} wwd_top_st_t;

	// synchroniser state
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
	} wwd_sync_st_t;

	// supply dip filter state
	typedef struct packed {
		logic [`WWD_UV_CNT_W-1:0] cnt;
		logic ok;
	} wwd_uv_st_t;

endpackage

// File: wwd_sync.sv
// two-flop synchroniser for the kick and supply comparator pins
`timescale 1ns/1ps
`include "wwd_regs.svh"

module wwd_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// asynchronous pins
	input wire logic [1:0] i_async,
	// synchronised levels
	output logic [1:0] o_sync
);

	// register state and next value
	wwd_pkg::wwd_sync_st_t q;
	wwd_pkg::wwd_sync_st_t d;

	// first stage feeds only the second stage
	always_comb
	begin
		d.meta = i_async;
		d.sync = q.meta;
	end

	// registers
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			q.meta <= `WWD_SYN_RST;
			q.sync <= `WWD_SYN_RST;
		end
		else
		begin
			q <= d;
		end
	end

	assign o_sync = q.sync;

endmodule // wwd_sync

// File: wwd_uv_filter.sv
// supply dip filter: ok drops only after a sustained low
`timescale 1ns/1ps
`include "wwd_regs.svh"

module wwd_uv_filter (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// synchronised comparator level, high above threshold
	input wire logic i_level,
	// filtered supply good
	output logic o_ok
);

	// dip length limit in cycles
	localparam logic [`WWD_UV_CNT_W-1:0] UV_LAST = `WWD_UV_CNT_W'(`WWD_UV_CYC - 1);

	// register state and next value
	wwd_pkg::wwd_uv_st_t q;
	wwd_pkg::wwd_uv_st_t d;

	// count consecutive low cycles, recover at once when high
	always_comb
	begin
		d = q;
		if (i_level)
		begin
			d.cnt = '0;
			d.ok = 1'b1;
		end
		else if (q.cnt == UV_LAST)
		begin
			d.ok = 1'b0;
		end
		else
		begin
			d.cnt = q.cnt + `WWD_UV_CNT_W'(1);
		end
	end

	// registers; supply counts as down until seen high
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			q.cnt <= '0;
			q.ok <= 1'b0;
		end
		else
		begin
			q <= d;
		end
	end

	assign o_ok = q.ok;

endmodule // wwd_uv_filter

// File: wwd_host_model.sv
// host controller model that pulls the kick pin low on request
`timescale 1ns/1ps

module wwd_host_model #(
	// cycles the kick pin is held low per kick
	parameter int unsigned LOW_CYC = 4
)(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// kick request from the bench, one cycle
	input wire logic i_kick_req,
	// kick pin, idles high through the pull-up
	output logic o_watchdog_kick
);
	// remaining low cycles of the kick pulse
	logic [3:0] low_q;

	// ----------------------------------------
	// kick pulse shaper
	// ----------------------------------------
	// low long enough that the falling edge is synchronised and seen once
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			low_q <= 4'h0;
		else if (i_kick_req)
			low_q <= 4'(LOW_CYC);
		else if (low_q != 4'h0)
			low_q <= low_q - 4'h1;
	end

	// pin released means the pull-up holds it high
	assign o_watchdog_kick = (low_q == 4'h0);
endmodule // wwd_host_model

// File: test_windowed_watchdog_supervisor.sv
// self-checking bench for the windowed watchdog supervisor
`timescale 1ns/1ps

module test_windowed_watchdog_supervisor;
	// shortened timing: period, pulse, windows, sleep
	localparam int P = 400;
	localparam int PU = 10;
	localparam int WIN = 480;
	localparam int SP = 200;
	localparam int SPU = 20;
	// clock, reset and pins
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic kick_req = 1'h0;
	logic supply_ok = 1'h0;
	logic kick;
	logic rst_n;
	logic en_n;
	logic sleep;
	// bookkeeping
	int errors = 0;
	int cmp_count = 0;
	int falls = 0;

	// ----------------------------------------
	// clock, design and host model
	// ----------------------------------------
	always #25 clk = ~clk;

	wwd_top #(.PERIOD_CYC(P), .SLEEP_PERIOD_CYC(SP), .SLEEP_PULSE_CYC(SPU)) DUT (
		.i_clk(clk),
		.i_arst_n(arst_n),
		.i_watchdog_kick(kick),
		.i_supply_ok(supply_ok),
		.o_host_init_pulse_n(rst_n),
		.o_sys_enable_n(en_n),
		.o_sleep_mode(sleep)
	);

	wwd_host_model host (
		.i_clk(clk),
		.i_arst_n(arst_n),
		.i_kick_req(kick_req),
		.o_watchdog_kick(kick)
	);

	// count reset pulses seen by the host
	always @(negedge rst_n)
		falls++;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// compare and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	// value inside a small tolerance band
	task automatic rng(input int n, input int lo, input int hi);
		chk({31'h0, (n >= lo) && (n <= hi)}, 32'h1);
	endtask

	// cycles until the reset output reaches a level
	task automatic wlv(input logic lv, input int lim, output int n);
		n = 0;
		while (rst_n !== lv && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	// one kick request
	task automatic do_kick();
		kick_req <= 1'h1;
		@(posedge clk);
		kick_req <= 1'h0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// power-on delay with an ignored kick
	task automatic t_por(input int pre);
		int n;
		supply_ok <= 1'h1;
		repeat (100) @(posedge clk);
		do_kick();
		chk(rst_n, 1'h0);
		wlv(1'h1, 700, n);
		rng(n + 101 + pre, P, P + 8);
		chk(en_n, 1'h1);
	endtask

	// three open-window kicks release enable
	task automatic t_good();
		int f0;
		f0 = falls;
		for (int i = 0; i < 3; i++)
		begin
			repeat (P) @(posedge clk);
			chk(en_n, 1'h1);
			do_kick();
		end
		repeat (8) @(posedge clk);
		chk(en_n, 1'h0);
		chk(falls, f0);
	endtask

	// closed-window kick is a fault
	task automatic t_early();
		int n;
		int f0;
		repeat (100) @(posedge clk);
		do_kick();
		wlv(1'h0, 10, n);
		rng(n, 1, 8);
		chk(en_n, 1'h1);
		wlv(1'h1, 40, n);
		chk(n, PU);
		f0 = falls;
		repeat (P) @(posedge clk);
		do_kick();
		repeat (20) @(posedge clk);
		chk(falls, f0);
	endtask

	// missed windows give a square wave then sleep
	task automatic t_miss();
		int n;
		for (int i = 0; i < 3; i++)
		begin
			chk(sleep, 1'h0);
			wlv(1'h0, 700, n);
			if (i > 0)
				rng(n, WIN - 2, WIN + 2);
			wlv(1'h1, 40, n);
			chk(n, PU);
		end
		repeat (3) @(posedge clk);
		chk(sleep, 1'h1);
	endtask

	// slow sleep pulses, then a kick wakes
	task automatic t_sleep();
		int n;
		wlv(1'h0, SP + 50, n);
		wlv(1'h1, 60, n);
		chk(n, SPU);
		wlv(1'h0, SP + 50, n);
		rng(n, SP - SPU - 2, SP - SPU + 2);
		wlv(1'h1, 60, n);
		repeat (5) @(posedge clk);
		do_kick();
		repeat (8) @(posedge clk);
		chk(sleep, 1'h0);
		chk(rst_n, 1'h1);
	endtask

	// short dip is filtered, long dip forces a new power-up
	task automatic t_dip();
		int n;
		supply_ok <= 1'h0;
		repeat (50) @(posedge clk);
		supply_ok <= 1'h1;
		repeat (10) @(posedge clk);
		chk(rst_n, 1'h1);
		supply_ok <= 1'h0;
		wlv(1'h0, 150, n);
		rng(n, 100, 108);
		@(posedge clk);
		chk(en_n, 1'h1);
		do_kick();
		repeat (10) @(posedge clk);
		chk(rst_n, 1'h0);
		t_por(0);
		t_good();
	endtask

	// ----------------------------------------
	// verdict, sequence and watchdog
	// ----------------------------------------
	task automatic final_report();
		$display("compares=%0d errors=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		arst_n <= 1'h1;
		repeat (2) @(posedge clk);
		chk(rst_n, 1'h0);
		t_por(0);
		t_good();
		t_early();
		t_miss();
		t_sleep();
		t_dip();
		final_report();
	end

	// cut a hang short
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report();
	end
endmodule // test_windowed_watchdog_supervisor
